// *** rtl/iet_pkg.sv ***
// Purpose: constants shared by the interrupt and event transfer unit
// Assumes: APB register access, 32-bit data, one aligned word per register
// Notes: node and channel register maps are laid out as below
package iet_pkg;
	localparam int         NODE_CNT     = 16;
	localparam int         CHAN_CNT     = 8;
	localparam int         LVL_W        = 4;
	localparam int         ADR_W        = 16;
	localparam int         CNT_W        = 8;
	localparam int         PIN_CNT      = 2;
	// first node's trap number; node n uses trap base plus n
	localparam logic [6:0] TRAP_BASE    = 7'h10;
	// nodes fed by the fast external pins
	localparam int         PIN_NODE0    = 14;
	// apb map
	localparam logic [11:0] OFS_NODE    = 12'h000;
	localparam logic [11:0] OFS_PINCFG  = 12'h080;
	localparam logic [11:0] OFS_STATUS  = 12'h084;
	localparam logic [11:0] OFS_CHAN    = 12'h100;
	localparam logic [11:0] OFS_CHAN_END = 12'h180;
	localparam logic [3:0]  CH_SRC      = 4'h0;
	localparam logic [3:0]  CH_DST      = 4'h4;
	localparam logic [3:0]  CH_CNT      = 4'h8;
	localparam logic [3:0]  CH_CTL      = 4'hC;
	// node control fields
	localparam int         NF_LVL       = 0;
	localparam int         NF_IE        = 6;
	localparam int         NF_IR        = 7;
	localparam int         NF_ROUTE     = 8;
	localparam int         NF_CHAN      = 9;
	// channel control fields
	localparam int         CF_WORD      = 0;
	localparam int         CF_INC_SRC   = 1;
	localparam int         CF_INC_DST   = 2;
	localparam int         CF_CONT      = 3;
	// edge modes
	localparam logic [1:0] EDGE_OFF     = 2'h0;
	localparam logic [1:0] EDGE_RISE    = 2'h1;
	localparam logic [1:0] EDGE_FALL    = 2'h2;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;
	localparam logic [1:0] KIND_NONE    = 2'h0;
	localparam logic [1:0] KIND_NODE    = 2'h1;
	localparam logic [1:0] KIND_CHAN    = 2'h2;
	localparam logic [1:0] KIND_MISC    = 2'h3;
	localparam int         RESP_CYCLES  = 8;
	typedef enum logic [1:0] {
		IET_IDLE = 2'b00,
		IET_ARB  = 2'b01,
		IET_IRQ  = 2'b11,
		IET_XFER = 2'b10
	} iet_state_type;
endpackage : iet_pkg

// *** rtl/iet_edge_detect.sv ***
// Purpose: programmable edge detector for one fast external pin
// Assumes: pin is synchronous to pclk
// Notes: mode off, rising, falling or both
`timescale 1ns/100ps
module iet_edge_detect
	import iet_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic       pin,
	input  wire logic [1:0] mode,
	output logic            edge_pulse
);
	logic pin_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev   <= 1'b0;
			edge_pulse <= 1'b0;
		end else if (ce) begin
			pin_prev <= pin;
			unique case (mode)
				EDGE_OFF:  edge_pulse <= 1'b0;
				EDGE_RISE: edge_pulse <= pin & ~pin_prev;
				EDGE_FALL: edge_pulse <= ~pin & pin_prev;
				EDGE_BOTH: edge_pulse <= pin ^ pin_prev;
			endcase
		end
	end

	a_rise_only : assert property (@(posedge pclk) disable iff (!presetn)
		ce && mode == EDGE_RISE && !pin && $past(pin) |=> !edge_pulse)
		else $error("rising mode fired on falling edge");
endmodule : iet_edge_detect

// *** rtl/iet_unit.sv ***
// Purpose: prioritised interrupt controller with eight event transfer channels
// Assumes: cpu_level is the priority of the service now running on the cpu
// Notes: no apb wait states; irq and transfer requests hold until the cpu acknowledges
// How it works
// - a pending enabled request reaches the cpu within eight clocks.
// - each node is routed to a vectored interrupt or a transfer channel.
// - a transfer takes one stolen cpu cycle, no vector branch.
// - a transfer moves byte or word, then bumps source, destination or both.
// - each transfer decrements the channel count unless continuous mode.
// - outside continuous mode, a channel count of zero turns the request into a vectored interrupt.
// - eight channels, each with source, destination and count.
// - each node has request flag, enable flag and level field.
// - level field selects one of sixteen levels.
// - only strictly higher levels than the running service are presented.
// - every node has its own distinct vector.
// - fast pins detect rising, falling or both edges.
// - a software trap number vectors to that trap's address.
// - software setting a node request bit raises a real request.
// - vector offset is the trap number times four.
`timescale 1ns/100ps
module iet_unit
	import iet_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [NODE_CNT-1:0] src_req,
	input  wire logic [PIN_CNT-1:0]  fast_pin,
	input  wire logic [LVL_W-1:0]    cpu_level,
	input  wire logic                trap_valid,
	input  wire logic [6:0]          trap_number,
	output logic                     trap_taken,
	output logic      [ADR_W-1:0]    trap_vector,
	output logic                     irq_req,
	output logic      [ADR_W-1:0]    irq_vector,
	output logic      [LVL_W-1:0]    irq_level,
	input  wire logic                irq_ack,
	output logic                     xfer_req,
	output logic      [ADR_W-1:0]    xfer_src,
	output logic      [ADR_W-1:0]    xfer_dst,
	output logic                     xfer_word,
	input  wire logic                xfer_ack
);
	logic [NODE_CNT-1:0] node_ir;
	logic [NODE_CNT-1:0] node_ie;
	logic [NODE_CNT-1:0] node_route;
	logic [LVL_W-1:0]    node_lvl  [NODE_CNT];
	logic [2:0]          node_chan [NODE_CNT];
	logic [ADR_W-1:0]    chan_src  [CHAN_CNT];
	logic [ADR_W-1:0]    chan_dst  [CHAN_CNT];
	logic [CNT_W-1:0]    chan_cnt  [CHAN_CNT];
	logic [3:0]          chan_ctl  [CHAN_CNT];
	logic [2*PIN_CNT-1:0] pin_mode;
	logic [PIN_CNT-1:0]  pin_edge;
	logic [NODE_CNT-1:0] hw_set;
	iet_state_type       state;
	logic [3:0]          win_node;
	logic [2:0]          win_chan;
	logic                found;
	logic [3:0]          next_win_node;
	logic [LVL_W-1:0]    next_win_lvl;
	logic                acc;
	logic                wr_en;
	logic [1:0]          kind;
	logic [3:0]          idx_node;
	logic [2:0]          idx_chan;
	logic [3:0]          reg_sel;

	function automatic logic [1:0] addr_kind(input logic [11:0] a);
		if (a[1:0] != 2'b00)
			return KIND_NONE;
		if (a < OFS_NODE + 12'(4 * NODE_CNT))
			return KIND_NODE;
		if (a == OFS_PINCFG || a == OFS_STATUS)
			return KIND_MISC;
		if (a >= OFS_CHAN && a < OFS_CHAN_END)
			return KIND_CHAN;
		return KIND_NONE;
	endfunction : addr_kind

	function automatic logic [ADR_W-1:0] node_vector(input logic [3:0] n);
		logic [6:0] trap;
		trap = TRAP_BASE + 7'(n);
		return {7'h00, trap, 2'b00};
	endfunction : node_vector

	assign acc      = psel & penable & pready;
	assign wr_en    = acc & pwrite;
	assign kind     = addr_kind(paddr);
	assign idx_node = paddr[5:2];
	assign idx_chan = paddr[6:4];
	assign reg_sel  = paddr[3:0];

	// fast pin edge detectors
	genvar gp;
	generate
		for (gp = 0; gp < PIN_CNT; gp++) begin : g_pin
			iet_edge_detect u_edge (
				.pclk       (pclk),
				.presetn    (presetn),
				.ce         (ce),
				.pin        (fast_pin[gp]),
				.mode       (pin_mode[2*gp +: 2]),
				.edge_pulse (pin_edge[gp])
			);
		end
	endgenerate

	always_comb begin
		hw_set = src_req;
		for (int p = 0; p < PIN_CNT; p++)
			hw_set[PIN_NODE0 + p] = src_req[PIN_NODE0 + p] | pin_edge[p];
	end

	// highest enabled level above the running service, lowest index on tie
	always_comb begin
		found         = 1'b0;
		next_win_node = 4'h0;
		next_win_lvl  = 4'h0;
		for (int i = 0; i < NODE_CNT; i++) begin
			if (node_ir[i] && node_ie[i] && node_lvl[i] > cpu_level
			    && (!found || node_lvl[i] > next_win_lvl)) begin
				found         = 1'b1;
				next_win_node = 4'(i);
				next_win_lvl  = node_lvl[i];
			end
		end
	end

	// apb handshake: no wait states, pready registered high in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (ce) begin
			pready  <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & (kind == KIND_NONE);
			prdata  <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				unique case (kind)
					KIND_NODE: prdata <= {20'h00000, node_chan[idx_node],
						node_route[idx_node], node_ir[idx_node],
						node_ie[idx_node], 2'b00, node_lvl[idx_node]};
					KIND_CHAN: unique case (reg_sel)
						CH_SRC:  prdata <= {16'h0000, chan_src[idx_chan]};
						CH_DST:  prdata <= {16'h0000, chan_dst[idx_chan]};
						CH_CNT:  prdata <= {24'h000000, chan_cnt[idx_chan]};
						default: prdata <= {28'h0000000, chan_ctl[idx_chan]};
					endcase
					KIND_MISC: prdata <= (paddr == OFS_PINCFG)
						? {28'h0000000, pin_mode}
						: {24'h000000, win_node, 2'b00, state};
					KIND_NONE: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// node control registers; hardware set wins over a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			node_ir    <= '0;
			node_ie    <= '0;
			node_route <= '0;
			for (int i = 0; i < NODE_CNT; i++) begin
				node_lvl[i]  <= 4'h0;
				node_chan[i] <= 3'h0;
			end
		end else if (ce) begin
			for (int i = 0; i < NODE_CNT; i++) begin
				if (wr_en && kind == KIND_NODE && idx_node == 4'(i)) begin
					node_lvl[i]   <= pwdata[NF_LVL +: LVL_W];
					node_ie[i]    <= pwdata[NF_IE];
					node_route[i] <= pwdata[NF_ROUTE];
					node_chan[i]  <= pwdata[NF_CHAN +: 3];
					node_ir[i]    <= pwdata[NF_IR] | hw_set[i];
				end else if ((irq_ack && state == IET_IRQ
				             || xfer_ack && state == IET_XFER)
				             && win_node == 4'(i)) begin
					node_ir[i] <= hw_set[i];
				end else if (hw_set[i]) begin
					node_ir[i] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_mode <= '0;
		else if (ce && wr_en && kind == KIND_MISC && paddr == OFS_PINCFG)
			pin_mode <= pwdata[2*PIN_CNT-1:0];
	end

	// transfer channels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < CHAN_CNT; c++) begin
				chan_src[c] <= 16'h0000;
				chan_dst[c] <= 16'h0000;
				chan_cnt[c] <= 8'h00;
				chan_ctl[c] <= 4'h0;
			end
		end else if (ce) begin
			for (int c = 0; c < CHAN_CNT; c++) begin
				if (wr_en && kind == KIND_CHAN && idx_chan == 3'(c)) begin
					unique case (reg_sel)
						CH_SRC:  chan_src[c] <= pwdata[ADR_W-1:0];
						CH_DST:  chan_dst[c] <= pwdata[ADR_W-1:0];
						CH_CNT:  chan_cnt[c] <= pwdata[CNT_W-1:0];
						default: chan_ctl[c] <= pwdata[3:0];
					endcase
				end else if (xfer_ack && state == IET_XFER && win_chan == 3'(c)) begin
					if (chan_ctl[c][CF_INC_SRC])
						chan_src[c] <= chan_src[c] + (chan_ctl[c][CF_WORD] ? 16'h0002 : 16'h0001);
					if (chan_ctl[c][CF_INC_DST])
						chan_dst[c] <= chan_dst[c] + (chan_ctl[c][CF_WORD] ? 16'h0002 : 16'h0001);
					if (!chan_ctl[c][CF_CONT])
						chan_cnt[c] <= chan_cnt[c] - 8'h01;
				end
			end
		end
	end

	// service sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state       <= IET_IDLE;
			win_node    <= 4'h0;
			win_chan    <= 3'h0;
			irq_req     <= 1'b0;
			irq_vector  <= 16'h0000;
			irq_level   <= 4'h0;
			xfer_req    <= 1'b0;
			xfer_src    <= 16'h0000;
			xfer_dst    <= 16'h0000;
			xfer_word   <= 1'b0;
		end else if (ce) begin
			unique case (state)
				IET_IDLE: if (found) begin
					win_node  <= next_win_node;
					win_chan  <= node_chan[next_win_node];
					irq_level <= next_win_lvl;
					state     <= IET_ARB;
				end
				IET_ARB: if (node_route[win_node] && (chan_cnt[win_chan] != 8'h00
				             || chan_ctl[win_chan][CF_CONT])) begin
					xfer_req  <= 1'b1;
					xfer_src  <= chan_src[win_chan];
					xfer_dst  <= chan_dst[win_chan];
					xfer_word <= chan_ctl[win_chan][CF_WORD];
					state     <= IET_XFER;
				end else begin
					irq_req    <= 1'b1;
					irq_vector <= node_vector(win_node);
					state      <= IET_IRQ;
				end
				IET_IRQ: if (irq_ack) begin
					irq_req <= 1'b0;
					state   <= IET_IDLE;
				end
				IET_XFER: if (xfer_ack) begin
					xfer_req <= 1'b0;
					state    <= IET_IDLE;
				end
			endcase
		end
	end

	// software traps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trap_taken  <= 1'b0;
			trap_vector <= 16'h0000;
		end else if (ce) begin
			trap_taken <= trap_valid;
			if (trap_valid)
				trap_vector <= {7'h00, trap_number, 2'b00};
		end
	end

	a_resp_time : assert property (@(posedge pclk) disable iff (!presetn)
		ce && state == IET_IDLE && found |-> ##[1:7] (irq_req || xfer_req))
		else $error("request not presented in time");
	a_strict_level : assert property (@(posedge pclk) disable iff (!presetn)
		$rose(irq_req) |-> irq_level > $past(cpu_level, 2))
		else $error("presented level not above running level");
	a_xfer_one_cycle : assert property (@(posedge pclk) disable iff (!presetn)
		ce && xfer_req && xfer_ack |=> !xfer_req && !irq_req)
		else $error("transfer held beyond its stolen cycle");
	a_cnt_decrement : assert property (@(posedge pclk) disable iff (!presetn)
		ce && state == IET_XFER && xfer_ack && !chan_ctl[win_chan][CF_CONT]
		&& !wr_en |=> chan_cnt[$past(win_chan)] == $past(chan_cnt[win_chan]) - 8'h01)
		else $error("count not decremented");
	a_cnt_continuous : assert property (@(posedge pclk) disable iff (!presetn)
		ce && state == IET_XFER && xfer_ack && chan_ctl[win_chan][CF_CONT]
		&& !wr_en |=> $stable(chan_cnt[$past(win_chan)]))
		else $error("continuous count changed");
	a_src_step : assert property (@(posedge pclk) disable iff (!presetn)
		ce && state == IET_XFER && xfer_ack && (chan_ctl[win_chan] & 4'h3) == 4'h3
		&& !wr_en |=> chan_src[$past(win_chan)] == $past(chan_src[win_chan]) + 16'h0002)
		else $error("word source pointer not advanced by two");
	a_zero_to_irq : assert property (@(posedge pclk) disable iff (!presetn)
		ce && state == IET_ARB && chan_cnt[win_chan] == 8'h00
		&& !chan_ctl[win_chan][CF_CONT] |=> irq_req && !xfer_req)
		else $error("exhausted channel did not interrupt");
	a_vector_map : assert property (@(posedge pclk) disable iff (!presetn)
		$rose(irq_req) |-> irq_vector == {5'h00, TRAP_BASE + 7'(win_node), 2'b00} + 16'h0000)
		else $error("vector is not trap number times four");
	a_ack_clears : assert property (@(posedge pclk) disable iff (!presetn)
		ce && state == IET_IRQ && irq_ack && !hw_set[win_node] && !wr_en
		|=> !node_ir[$past(win_node)])
		else $error("request flag not cleared on acceptance");
	a_disabled_idle : assert property (@(posedge pclk) disable iff (!presetn)
		ce && state == IET_IDLE && (node_ir & node_ie) == '0 |=> state == IET_IDLE)
		else $error("disabled request was serviced");
	a_trap_vector : assert property (@(posedge pclk) disable iff (!presetn)
		ce && trap_valid |=> trap_taken && trap_vector[8:2] == $past(trap_number))
		else $error("trap vector wrong");

	c_irq_served : cover property (@(posedge pclk) irq_req && irq_ack);
	c_xfer_served : cover property (@(posedge pclk) xfer_req && xfer_ack);
	c_exhausted : cover property (@(posedge pclk)
		state == IET_ARB && node_route[win_node] && chan_cnt[win_chan] == 8'h00);
	c_trap : cover property (@(posedge pclk) trap_taken);
endmodule : iet_unit

// *** sim/iet_cpu_model.sv ***
// Purpose: cpu core stand-in that accepts interrupt and transfer requests
// Assumes: requests are levels held until acknowledged
// Notes: ack_delay sets how many cycles each answer waits
`timescale 1ns/100ps
module iet_cpu_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] ack_delay,
	input  wire logic       irq_req,
	input  wire logic       xfer_req,
	output logic            irq_ack,
	output logic            xfer_ack
);
	logic [3:0] irq_wait;
	logic [3:0] xfer_wait;

	// accept one vectored service per request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack  <= 1'b0;
			irq_wait <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			if (irq_req && !irq_ack) begin
				if (irq_wait >= ack_delay) begin
					irq_ack  <= 1'b1;
					irq_wait <= 4'h0;
				end else begin
					irq_wait <= irq_wait + 4'h1;
				end
			end
		end
	end

	// one stolen cycle per move, no vector taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_ack  <= 1'b0;
			xfer_wait <= 4'h0;
		end else begin
			xfer_ack <= 1'b0;
			if (xfer_req && !xfer_ack) begin
				if (xfer_wait >= ack_delay) begin
					xfer_ack  <= 1'b1;
					xfer_wait <= 4'h0;
				end else begin
					xfer_wait <= xfer_wait + 4'h1;
				end
			end
		end
	end
endmodule : iet_cpu_model

// *** sim/iet_unit_tb.sv ***
// Purpose: self-checking bench for the interrupt and event transfer unit
// Assumes: apb master with one request at a time
// Notes: every service seen at the cpu side must match a queued note
`timescale 1ns/100ps
module iet_unit_tb
	import iet_pkg::*;
;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, trap_valid, trap_taken;
	logic irq_req, irq_ack, xfer_req, xfer_ack, xfer_word;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [NODE_CNT-1:0] src_req;
	logic [PIN_CNT-1:0] fast_pin;
	logic [LVL_W-1:0] cpu_level, irq_level;
	logic [6:0] trap_number;
	logic [ADR_W-1:0] trap_vector, irq_vector, xfer_src, xfer_dst, s;
	logic [3:0] ack_delay;
	logic [34:0] exp_q[$];
	int err_count, num_checks, seed, n, m;

	iet_unit u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_req(src_req), .fast_pin(fast_pin), .cpu_level(cpu_level),
		.trap_valid(trap_valid), .trap_number(trap_number), .trap_taken(trap_taken),
		.trap_vector(trap_vector), .irq_req(irq_req), .irq_vector(irq_vector),
		.irq_level(irq_level), .irq_ack(irq_ack), .xfer_req(xfer_req), .xfer_src(xfer_src),
		.xfer_dst(xfer_dst), .xfer_word(xfer_word), .xfer_ack(xfer_ack));
	iet_cpu_model u_cpu (.pclk(pclk), .presetn(presetn), .ack_delay(ack_delay),
		.irq_req(irq_req), .xfer_req(xfer_req), .irq_ack(irq_ack), .xfer_ack(xfer_ack));

	always #5 pclk = ~pclk;

	task chk(input string what, input logic [34:0] e, input logic [34:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		m = 0;
		do begin
			@(posedge pclk);
			m++;
		end while (pready !== 1'b1 && m < 20);
		chk("pready", 35'h1, {34'h0, pready});
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] e, input logic er);
		apb(1'b0, a, 32'h0);
		chk("read data", {2'h0, e, er}, {2'h0, prdata, pslverr});
	endtask : rd

	task expect_ev(input logic [1:0] k, input logic w, input logic [15:0] a, input logic [15:0] b);
		exp_q.push_back({k, w, a, b});
	endtask : expect_ev

	task drain(input string name);
		n = 0;
		while (exp_q.size() != 0 && n < 80) begin
			@(posedge pclk);
			n++;
		end
		chk("pending services", 35'h0, 35'(exp_q.size()));
		repeat (4) @(posedge pclk);
		$display("test %s done", name);
	endtask : drain

	task pulse_src(input int i);
		@(posedge pclk);
		src_req[i] <= 1'b1;
		@(posedge pclk);
		src_req[i] <= 1'b0;
	endtask : pulse_src

	// watches the cpu side and matches each service against the oldest note
	always @(posedge pclk) begin
		if (presetn === 1'b1) begin
			if (irq_req === 1'b1 && irq_ack === 1'b1) begin
				if (exp_q.size() == 0) chk("unexpected irq", 35'h0, {2'h1, 1'b0, irq_vector, 16'h0});
				else chk("irq service", exp_q.pop_front(), {2'h1, 1'b0, irq_vector, 12'h0, irq_level});
			end
			if (xfer_req === 1'b1 && xfer_ack === 1'b1) begin
				if (exp_q.size() == 0) chk("unexpected xfer", 35'h0, {2'h2, xfer_word, xfer_src, xfer_dst});
				else chk("xfer service", exp_q.pop_front(), {2'h2, xfer_word, xfer_src, xfer_dst});
			end
			if (trap_taken === 1'b1) begin
				if (exp_q.size() == 0) chk("unexpected trap", 35'h0, {2'h3, 1'b0, trap_vector, 16'h0});
				else chk("trap service", exp_q.pop_front(), {2'h3, 1'b0, trap_vector, 16'h0});
			end
		end
	end

	initial begin
		#200000;
		err_count++;
		end_sim();
	end

	initial begin
		{pclk, ce, psel, penable, pwrite, trap_valid} = 6'b010000;
		{paddr, pwdata, src_req, fast_pin, cpu_level, trap_number} = '0;
		ack_delay = 4'h0;
		err_count = 0;
		num_checks = 0;
		seed = 37626;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h000, 32'h0, 1'b0);
		rd(12'h108, 32'h0, 1'b0);
		rd(12'h090, 32'h0, 1'b1);
		// software set on a free node, response time
		apb(1'b1, 12'h00C, 32'hC5);
		expect_ev(2'h1, 1'b0, 16'h004C, 16'h5);
		n = 0;
		while (irq_req !== 1'b1 && n < 12) begin
			@(posedge pclk);
			n++;
		end
		chk("response cycles", 35'h1, 35'(n <= 8));
		drain("software request");
		rd(12'h00C, 32'h45, 1'b0);
		// priority order, blocking and disabled nodes
		cpu_level <= 4'hF;
		apb(1'b1, 12'h008, 32'hC3);
		apb(1'b1, 12'h014, 32'hC9);
		apb(1'b1, 12'h01C, 32'h8C);
		repeat (10) @(posedge pclk);
		expect_ev(2'h1, 1'b0, 16'h0054, 16'h9);
		expect_ev(2'h1, 1'b0, 16'h0048, 16'h3);
		cpu_level <= 4'h0;
		drain("priority");
		cpu_level <= 4'h4;
		apb(1'b1, 12'h018, 32'hC4);
		repeat (10) @(posedge pclk);
		rd(12'h018, 32'hC4, 1'b0);
		expect_ev(2'h1, 1'b0, 16'h0058, 16'h4);
		cpu_level <= 4'h3;
		drain("nesting");
		rd(12'h01C, 32'h8C, 1'b0);
		// counted word transfers ending in a vectored interrupt
		ack_delay <= 4'h5;
		cpu_level <= 4'h0;
		s = 16'($random(seed));
		apb(1'b1, 12'h120, {16'h0, s});
		apb(1'b1, 12'h124, 32'h200);
		apb(1'b1, 12'h128, 32'h2);
		apb(1'b1, 12'h12C, 32'h7);
		apb(1'b1, 12'h004, 32'h542);
		for (int i = 0; i < 3; i++) begin
			if (i < 2) expect_ev(2'h2, 1'b1, s + 16'(2 * i), 16'(16'h200 + 2 * i));
			else expect_ev(2'h1, 1'b0, 16'h0044, 16'h2);
			pulse_src(1);
			drain("word transfer");
		end
		rd(12'h128, 32'h0, 1'b0);
		// continuous byte transfers keep the count
		apb(1'b1, 12'h150, 32'h30);
		apb(1'b1, 12'h154, 32'h80);
		apb(1'b1, 12'h158, 32'h1);
		apb(1'b1, 12'h15C, 32'hC);
		apb(1'b1, 12'h010, 32'hB41);
		for (int i = 0; i < 2; i++) begin
			expect_ev(2'h2, 1'b0, 16'h30, 16'(16'h80 + i));
			pulse_src(4);
			drain("continuous transfer");
		end
		rd(12'h158, 32'h1, 1'b0);
		// fast pin edge modes
		ack_delay <= 4'h0;
		apb(1'b1, 12'h038, 32'h43);
		for (int md = 0; md < 4; md++) begin
			apb(1'b1, 12'h080, 32'(md));
			repeat (3) @(posedge pclk);
			if (md % 2 == 1) expect_ev(2'h1, 1'b0, 16'h0078, 16'h3);
			fast_pin[0] <= 1'b1;
			drain("pin rise");
			if (md >= 2) expect_ev(2'h1, 1'b0, 16'h0078, 16'h3);
			fast_pin[0] <= 1'b0;
			drain("pin fall");
		end
		rd(12'h080, 32'h3, 1'b0);
		rd(12'h084, 32'hE0, 1'b0);
		// software traps
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			trap_number <= 7'($random(seed));
			trap_valid  <= 1'b1;
			@(posedge pclk);
			trap_valid  <= 1'b0;
			expect_ev(2'h3, 1'b0, {7'h0, trap_number, 2'b00}, 16'h0);
			drain("trap");
		end
		// clock enable low must drop a request pulse
		ce <= 1'b0;
		pulse_src(3);
		@(posedge pclk);
		ce <= 1'b1;
		rd(12'h00C, 32'h45, 1'b0);
		drain("clock enable");
		end_sim();
	end
endmodule : iet_unit_tb
